//--- core/daq_host_register_interface.sv
// Host register bank of the data acquisition board.
// Assumes a byte-wide host strobe bus and converter logic on i_clk.
module daq_host_register_interface
   import daq_regs_pkg::*;
#(
   parameter int RESULT_BITS       = 12,
   parameter int FIFO_DEPTH        = 4,
   parameter bit HAS_PARALLEL_PORT = 1'b1
)
(
   input  wire logic                   i_clk,
   input  wire logic                   i_resetn,
   input  wire logic [15:0]            i_io_window_origin,
   input  wire logic [15:0]            i_io_addr,
   input  wire logic                   i_io_wr,
   input  wire logic                   i_io_rd,
   input  wire logic [7:0]             i_io_wdata,
   output      logic [7:0]             o_io_rdata,
   output      logic                   o_io_rdata_oe,
   input  wire logic [3:0]             i_gp_inputs,
   input  wire logic                   i_pacer_tick,
   input  wire logic                   i_polarity_indication,
   input  wire logic                   i_single_ended,
   input  wire logic                   i_conv_done,
   input  wire logic [RESULT_BITS-1:0] i_conv_result,
   output      logic                   o_conv_start,
   output      logic [3:0]             o_conv_input,
   output      logic [3:0]             o_gp_outputs,
   output      logic                   o_counter_zero_gate,
   output      logic                   o_irq_request,
   output      logic [1:0]             o_gain_select,
   output      logic [11:0]            o_analog_out0,
   output      logic [11:0]            o_analog_out1
);

   localparam int PTR_W = $clog2(FIFO_DEPTH);

   if (RESULT_BITS != 12 && RESULT_BITS != 16)
   begin
      $error("RESULT_BITS must be 12 or 16");
   end
   if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0)
   begin
      $error("FIFO_DEPTH must be a power of two of at least 2");
   end

   typedef struct packed
   {
      logic [FIFO_DEPTH-1:0][15:0] fifo_res;
      logic [FIFO_DEPTH-1:0][3:0]  fifo_src;
      logic [PTR_W-1:0]            wr_ptr;
      logic [PTR_W-1:0]            rd_ptr;
      logic [PTR_W:0]              count;
      logic [15:0]                 last_res;
      logic [3:0]                  last_src;
      logic                        busy;
      logic [3:0]                  conv_src;
      logic [3:0]                  cur_chan;
      logic [7:0]                  scan_limits;
      logic [7:0]                  external_start_input_ctrl;
      logic [7:0]                  pacing;
      logic [1:0]                  gain;
      logic [2:0][7:0]             counter_data;
      logic [7:0]                  counter_ctrl;
      logic [3:0]                  gp_out;
      logic [3:0]                  ao0_lo;
      logic [3:0]                  ao1_lo;
      logic [11:0]                 ao0;
      logic [11:0]                 ao1;
      logic [2:0][7:0]             port_data;
      logic [7:0]                  port_config;
      logic                        conv_en;
      logic                        burst_en;
      logic                        ext_en;
      logic                        int_flag;
      logic [7:0]                  rdata;
      logic                        rdata_oe;
      logic                        conv_start;
      logic                        cz_gate;
      logic                        irq;
   } regs_s;

   regs_s st_q;
   regs_s st_d;

   gp_input_if gp ();

   gp_input_filter u_filter
   (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_pins   (i_gp_inputs),
      .o_filt   (gp)
   );

   // Returns one for a mapped access and gives its offset in the window.
   function automatic logic decode(input logic [15:0] addr,
                                   input logic [15:0] origin,
                                   output logic [11:0] ofs);
      logic [15:0] diff;
      diff = addr - origin;
      ofs = diff[11:0];
      decode = 1'b0;
      if (diff[15:4] == 12'h000)
      begin
         decode = 1'b1;
      end
      else if (diff[15:3] == 13'h0080)
      begin
         decode = HAS_PARALLEL_PORT || diff[2];
      end
   endfunction

   function automatic logic [7:0] low_byte(input logic [15:0] res,
                                           input logic [3:0] src);
      if (RESULT_BITS == 12)
      begin
         low_byte = {res[3:0], src};
      end
      else
      begin
         low_byte = res[7:0];
      end
   endfunction

   function automatic logic [7:0] high_byte(input logic [15:0] res);
      if (RESULT_BITS == 12)
      begin
         high_byte = res[11:4];
      end
      else
      begin
         high_byte = res[15:8];
      end
   endfunction

   function automatic logic [3:0] next_chan(input logic [3:0] cur,
                                            input logic [7:0] lim);
      if (cur == lim[7:4])
      begin
         next_chan = lim[3:0];
      end
      else
      begin
         next_chan = cur + 4'h1;
      end
   endfunction

   logic        wr_hit;
   logic        rd_hit;
   logic [11:0] wr_ofs;
   logic [11:0] rd_ofs;
   logic        hw_start;
   logic        pacer_ok;
   logic        start;
   logic [15:0] done_res;

   always_comb
   begin
      wr_hit = i_io_wr && decode(i_io_addr, i_io_window_origin, wr_ofs);
      rd_hit = i_io_rd && decode(i_io_addr, i_io_window_origin, rd_ofs);
      // The pacer runs only while input 0 is high when gating is on.
      pacer_ok = i_pacer_tick &&
                 (!st_q.pacing[PACING_GATE_BIT] || gp.level[0]);
      hw_start = 1'b0;
      case (start_sel_e'(st_q.external_start_input_ctrl[1:0]))
         START_EDGE:  hw_start = gp.rise0;
         START_PACER: hw_start = pacer_ok;
         default:     hw_start = 1'b0;
      endcase
      start = (wr_hit && wr_ofs == OFS_RESULT_LO)
              || (st_q.conv_en && hw_start);
      done_res = 16'h0000;
      done_res[RESULT_BITS-1:0] = i_conv_result;
   end

   always_comb
   begin
      st_d = st_q;
      st_d.conv_start = 1'b0;
      st_d.rdata_oe = 1'b0;
      st_d.rdata = UNDEF_READ;

      // A start while busy is dropped; the input steps within the limits.
      if (start && !st_q.busy)
      begin
         st_d.conv_start = 1'b1;
         st_d.busy = 1'b1;
         st_d.conv_src = st_q.cur_chan;
         st_d.cur_chan = next_chan(st_q.cur_chan, st_q.scan_limits);
      end

      // A finished result enters the FIFO; a full FIFO drops it.
      if (i_conv_done && st_q.busy)
      begin
         st_d.busy = 1'b0;
         if (st_q.count != (PTR_W + 1)'(FIFO_DEPTH))
         begin
            st_d.fifo_res[st_q.wr_ptr] = done_res;
            st_d.fifo_src[st_q.wr_ptr] = st_q.conv_src;
            st_d.wr_ptr = st_q.wr_ptr + 1'b1;
            st_d.count = st_d.count + 1'b1;
         end
      end

      // Reads answer one cycle later on the driven data bus.
      if (rd_hit)
      begin
         st_d.rdata_oe = 1'b1;
         case (rd_ofs)
            OFS_RESULT_LO:
            begin
               // Popping latches the whole entry so offset one matches.
               if (st_q.count != '0)
               begin
                  st_d.last_res = st_q.fifo_res[st_q.rd_ptr];
                  st_d.last_src = st_q.fifo_src[st_q.rd_ptr];
                  st_d.rd_ptr = st_q.rd_ptr + 1'b1;
                  st_d.count = st_d.count - 1'b1;
               end
               st_d.rdata = low_byte(st_d.last_res, st_d.last_src);
            end
            OFS_RESULT_HI:    st_d.rdata = high_byte(st_q.last_res);
            OFS_SCAN_LIMITS:  st_d.rdata = st_q.scan_limits;
            OFS_NIBBLE_DIO:   st_d.rdata = {DIO_READ_TOP, gp.level};
            OFS_STATUS:
            begin
               st_d.rdata = {st_q.busy, i_polarity_indication,
                             i_single_ended, st_q.int_flag,
                             st_q.cur_chan};
            end
            OFS_EXTERNAL_START_INPUT_CTRL:    st_d.rdata = st_q.external_start_input_ctrl;
            OFS_GAIN:         st_d.rdata = {6'h00, st_q.gain};
            OFS_COUNTER0:     st_d.rdata = st_q.counter_data[0];
            OFS_COUNTER1:     st_d.rdata = st_q.counter_data[1];
            OFS_COUNTER2:     st_d.rdata = st_q.counter_data[2];
            OFS_PORT_A:       st_d.rdata = st_q.port_data[0];
            OFS_PORT_B:       st_d.rdata = st_q.port_data[1];
            OFS_PORT_C:       st_d.rdata = st_q.port_data[2];
            OFS_EXT_STATUS:
            begin
               st_d.rdata = {5'h00, st_q.ext_en, st_q.burst_en,
                             st_q.conv_en};
            end
            // Write-only locations answer with a fixed byte.
            default:          st_d.rdata = UNDEF_READ;
         endcase
      end

      if (wr_hit)
      begin
         case (wr_ofs)
            OFS_SCAN_LIMITS:
            begin
               st_d.scan_limits = i_io_wdata;
               st_d.cur_chan = i_io_wdata[3:0];
               st_d.wr_ptr = '0;
               st_d.rd_ptr = '0;
               st_d.count = '0;
            end
            OFS_NIBBLE_DIO:   st_d.gp_out = i_io_wdata[3:0];
            OFS_AOUT0_LO:     st_d.ao0_lo = i_io_wdata[7:4];
            OFS_AOUT0_HI:     st_d.ao0 = {i_io_wdata, st_q.ao0_lo};
            OFS_AOUT1_LO:     st_d.ao1_lo = i_io_wdata[7:4];
            OFS_AOUT1_HI:     st_d.ao1 = {i_io_wdata, st_q.ao1_lo};
            OFS_EXTERNAL_START_INPUT_CTRL:    st_d.external_start_input_ctrl = i_io_wdata;
            OFS_BURST_PACING: st_d.pacing = i_io_wdata;
            OFS_GAIN:         st_d.gain = i_io_wdata[1:0];
            OFS_COUNTER0:     st_d.counter_data[0] = i_io_wdata;
            OFS_COUNTER1:     st_d.counter_data[1] = i_io_wdata;
            OFS_COUNTER2:     st_d.counter_data[2] = i_io_wdata;
            OFS_COUNTER_CTRL: st_d.counter_ctrl = i_io_wdata;
            OFS_PORT_A:       st_d.port_data[0] = i_io_wdata;
            OFS_PORT_B:       st_d.port_data[1] = i_io_wdata;
            OFS_PORT_C:       st_d.port_data[2] = i_io_wdata;
            OFS_PORT_CONFIG:  st_d.port_config = i_io_wdata;
            OFS_CONV_ENABLE:  st_d.conv_en = i_io_wdata[0];
            OFS_BURST_ENABLE: st_d.burst_en = i_io_wdata[0];
            OFS_EXT_ENABLE:   st_d.ext_en = i_io_wdata[0];
            default:          st_d.gp_out = st_d.gp_out;
         endcase
      end

      // A completion in the same cycle as the clear keeps the flag set.
      if (wr_hit && wr_ofs == OFS_STATUS)
      begin
         st_d.int_flag = 1'b0;
      end
      if (i_conv_done && st_q.busy && st_q.external_start_input_ctrl[EXTERNAL_START_INPUT_INTE_BIT])
      begin
         st_d.int_flag = 1'b1;
      end

      st_d.irq = st_d.int_flag;
      st_d.cz_gate = gp.level[2];
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign o_io_rdata          = st_q.rdata;
   assign o_io_rdata_oe       = st_q.rdata_oe;
   assign o_conv_start        = st_q.conv_start;
   assign o_conv_input        = st_q.conv_src;
   assign o_gp_outputs        = st_q.gp_out;
   assign o_counter_zero_gate = st_q.cz_gate;
   assign o_irq_request       = st_q.irq;
   assign o_gain_select       = st_q.gain;
   assign o_analog_out0       = st_q.ao0;
   assign o_analog_out1       = st_q.ao1;

endmodule

//--- core/daq_regs_pkg.sv
// Constants shared by the acquisition board register bank.
// Assumes byte-wide host I/O accesses on the single 250 MHz core clock.
package daq_regs_pkg;

   // Offsets from the switch-set I/O window origin.
   localparam logic [11:0] OFS_RESULT_LO     = 12'h000;
   localparam logic [11:0] OFS_RESULT_HI     = 12'h001;
   localparam logic [11:0] OFS_SCAN_LIMITS   = 12'h002;
   localparam logic [11:0] OFS_NIBBLE_DIO    = 12'h003;
   localparam logic [11:0] OFS_AOUT0_LO      = 12'h004;
   localparam logic [11:0] OFS_AOUT0_HI      = 12'h005;
   localparam logic [11:0] OFS_AOUT1_LO      = 12'h006;
   localparam logic [11:0] OFS_AOUT1_HI      = 12'h007;
   localparam logic [11:0] OFS_STATUS        = 12'h008;
   localparam logic [11:0] OFS_EXTERNAL_START_INPUT_CTRL     = 12'h009;
   localparam logic [11:0] OFS_BURST_PACING  = 12'h00A;
   localparam logic [11:0] OFS_GAIN          = 12'h00B;
   localparam logic [11:0] OFS_COUNTER0      = 12'h00C;
   localparam logic [11:0] OFS_COUNTER1      = 12'h00D;
   localparam logic [11:0] OFS_COUNTER2      = 12'h00E;
   localparam logic [11:0] OFS_COUNTER_CTRL  = 12'h00F;
   localparam logic [11:0] OFS_PORT_A        = 12'h400;
   localparam logic [11:0] OFS_PORT_B        = 12'h401;
   localparam logic [11:0] OFS_PORT_C        = 12'h402;
   localparam logic [11:0] OFS_PORT_CONFIG   = 12'h403;
   localparam logic [11:0] OFS_CONV_ENABLE   = 12'h404;
   localparam logic [11:0] OFS_BURST_ENABLE  = 12'h405;
   localparam logic [11:0] OFS_EXT_ENABLE    = 12'h406;
   localparam logic [11:0] OFS_EXT_STATUS    = 12'h407;

   // Field positions.
   localparam int STAT_BUSY_BIT     = 7;
   localparam int STAT_POLARITY_BIT = 6;
   localparam int STAT_MUX_BIT      = 5;
   localparam int STAT_INT_BIT      = 4;
   localparam int EXTERNAL_START_INPUT_INTE_BIT     = 7;
   localparam int PACING_GATE_BIT   = 0;

   // Start source codes held in the low two bits of the trigger control.
   typedef enum logic [1:0]
   {
      START_SOFT_A = 2'b00,
      START_SOFT_B = 2'b01,
      START_EDGE   = 2'b10,
      START_PACER  = 2'b11
   } start_sel_e;

   // Values after reset and fixed read values.
   localparam logic [7:0] RESET_BYTE   = 8'h00;
   localparam logic [3:0] RESET_NIBBLE = 4'h0;
   localparam logic [7:0] UNDEF_READ   = 8'h00;
   localparam logic [3:0] DIO_READ_TOP = 4'h0;

endpackage

//--- core/gp_input_if.sv
// Carries the filtered general-purpose input levels between modules.
// Assumes both ends run on the same core clock.
interface gp_input_if;
   logic [3:0] level;
   logic       rise0;
   modport src (output level, output rise0);
   modport dst (input level, input rise0);
endinterface

//--- core/gp_input_filter.sv
// Three-stage pin filter for the four general-purpose inputs.
// Assumes the pins are asynchronous to i_clk.
module gp_input_filter
   import daq_regs_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_resetn,
   input  wire logic [3:0] i_pins,
   gp_input_if.src         o_filt
);

   typedef struct packed
   {
      logic [3:0] s1;
      logic [3:0] s2;
      logic [3:0] s3;
      logic [3:0] level;
      logic       rise0;
   } filt_s;

   filt_s st_q;
   filt_s st_d;

   always_comb
   begin
      st_d = st_q;
      st_d.s1 = i_pins;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      st_d.rise0 = 1'b0;
      // A level counts once the second and third stages agree.
      for (int b = 0; b < 4; b++)
      begin
         if (st_q.s2[b] == st_q.s3[b])
         begin
            st_d.level[b] = st_q.s3[b];
         end
      end
      st_d.rise0 = st_d.level[0] & ~st_q.level[0];
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign o_filt.level = st_q.level;
   assign o_filt.rise0 = st_q.rise0;

endmodule

//--- tb/daq_host_register_interface_properties.sv
// Concurrent checks of the acquisition register bank at its top ports.
// Assumes a static window origin and one-cycle host strobes.
module daq_host_register_interface_properties
   import daq_regs_pkg::*;
(
   input wire logic        i_clk,
   input wire logic        i_resetn,
   input wire logic [15:0] i_io_window_origin,
   input wire logic [15:0] i_io_addr,
   input wire logic        i_io_wr,
   input wire logic        i_io_rd,
   input wire logic [7:0]  i_io_wdata,
   input wire logic [7:0]  o_io_rdata,
   input wire logic        o_io_rdata_oe,
   input wire logic [3:0]  i_gp_inputs,
   input wire logic        i_conv_done,
   input wire logic        o_conv_start,
   input wire logic        o_counter_zero_gate,
   input wire logic        o_irq_request,
   input wire logic [11:0] o_analog_out0
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] ofs;
   logic        busy_q;
   logic        busy_d;

   default clocking @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);

   assign ofs = i_io_addr - i_io_window_origin;

   // A start arriving while a conversion runs is ignored, so track busy.
   always_comb
   begin
      busy_d = busy_q;
      if (o_conv_start)
         busy_d = 1'b1;
      else if (i_conv_done)
         busy_d = 1'b0;
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
         busy_q <= 1'b0;
      else
         busy_q <= busy_d;
   end

   a_start_on_write: assert property (
      i_io_wr && ofs == 16'h0000 && !busy_q && !o_conv_start
      |=> o_conv_start)
      else $error("No start after a write to offset zero.");
   a_read_answered: assert property (
      i_io_rd && ofs < 16'h0010 |=> o_io_rdata_oe)
      else $error("Mapped read was not answered.");
   a_unmapped_quiet: assert property (
      i_io_rd && ofs inside {[16'h0010:16'h03FF]}
      |=> !o_io_rdata_oe && o_io_rdata == 8'h00)
      else $error("Unmapped read drove the data bus.");
   a_write_only_zero: assert property (
      i_io_rd && ofs inside {16'h0004, 16'h0005, 16'h0006, 16'h0007,
      16'h000A, 16'h000F} |=> o_io_rdata == UNDEF_READ)
      else $error("Write-only location returned data.");
   a_dio_top_zero: assert property (
      i_io_rd && ofs == 16'h0003 |=> o_io_rdata[7:4] == DIO_READ_TOP)
      else $error("Digital input read has a nonzero top nibble.");
   a_scan_readback: assert property (
      i_io_wr && ofs == 16'h0002 ##1 i_io_rd && ofs == 16'h0002
      |=> o_io_rdata == $past(i_io_wdata, 2))
      else $error("Scan limits did not read back.");
   a_aout_low_held: assert property (
      i_io_wr && ofs == 16'h0004 |=> $stable(o_analog_out0))
      else $error("Analog output moved on a low byte write.");
   a_aout_high_load: assert property (
      i_io_wr && ofs == 16'h0005
      |=> o_analog_out0[11:4] == $past(i_io_wdata))
      else $error("Analog output missed its upper byte.");
   a_irq_cleared: assert property (
      i_io_wr && ofs == 16'h0008 && !i_conv_done |=> !o_irq_request)
      else $error("Status write did not clear the interrupt.");
   a_gate_follows: assert property (
      i_gp_inputs[2] [*8] |-> o_counter_zero_gate)
      else $error("Counter gate does not follow input two.");
endmodule

bind daq_host_register_interface daq_host_register_interface_properties
   props_i (.i_clk, .i_resetn, .i_io_window_origin, .i_io_addr, .i_io_wr,
   .i_io_rd, .i_io_wdata, .o_io_rdata, .o_io_rdata_oe, .i_gp_inputs,
   .i_conv_done, .o_conv_start, .o_counter_zero_gate, .o_irq_request,
   .o_analog_out0);

//--- tb/conv_model.sv
// Behavioural converter standing on the far side of the register bank.
// Assumes one start pulse per conversion and a fixed conversion time.
module conv_model
#(
   parameter int LATENCY = 5
)
(
   input  wire logic        i_clk,
   input  wire logic        i_start,
   input  wire logic [11:0] i_value,
   output      logic        o_done,
   output      logic [11:0] o_result
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;

   initial o_done = 1'b0;
   initial o_result = 12'h000;

   // Outside the done pulse the result toggles, so stale data never matches.
   always @(posedge i_clk)
   begin
      o_done <= (cnt == 1);
      o_result <= (cnt == 1) ? i_value : ~o_result;
      if (i_start)
         cnt <= LATENCY;
      else if (cnt != 0)
         cnt <= cnt - 1;
   end
endmodule

//--- tb/testbench.sv
// Self-checking bench of the acquisition register bank.
// Assumes a fixed window origin and the converter model on the far side.
module testbench
   import daq_regs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] ORG = 16'h0300;
   localparam logic [11:0] WO [8] = '{OFS_AOUT0_LO, OFS_AOUT0_HI,
      OFS_AOUT1_LO, OFS_AOUT1_HI, OFS_BURST_PACING, OFS_COUNTER_CTRL,
      OFS_PORT_CONFIG, OFS_CONV_ENABLE};
   // Each entry: start code, pacing gate, input 0 level, expected starts.
   localparam logic [4:0] TCASE [6] = '{5'b00010, 5'b01010, 5'b10011,
      5'b11011, 5'b11100, 5'b11111};
   logic        i_clk = 1'b0;
   logic        i_resetn = 1'b0;
   logic [15:0] i_io_addr = 16'h0000;
   logic        i_io_wr = 1'b0;
   logic        i_io_rd = 1'b0;
   logic [7:0]  i_io_wdata = 8'h00;
   logic [3:0]  i_gp_inputs = 4'h0;
   logic        i_pacer_tick = 1'b0;
   logic        i_polarity_indication = 1'b1;
   logic        i_single_ended = 1'b0;
   logic [11:0] conv_value = 12'h000;
   logic        i_conv_done;
   logic [11:0] i_conv_result;
   logic [7:0]  o_io_rdata;
   logic        o_io_rdata_oe, o_conv_start, o_counter_zero_gate;
   logic        o_irq_request;
   logic [3:0]  o_conv_input, o_gp_outputs;
   logic [1:0]  o_gain_select;
   logic [11:0] o_analog_out0, o_analog_out1;
   logic [7:0]  rdata16, rd16;
   int          error_cnt = 0, n_tests = 0, cyc = 0, starts = 0;

   daq_host_register_interface #(.RESULT_BITS(12))
      daq_host_register_interface_i (.i_clk, .i_resetn,
      .i_io_window_origin(ORG), .i_io_addr, .i_io_wr, .i_io_rd,
      .i_io_wdata, .o_io_rdata, .o_io_rdata_oe, .i_gp_inputs,
      .i_pacer_tick, .i_polarity_indication, .i_single_ended, .i_conv_done,
      .i_conv_result, .o_conv_start, .o_conv_input, .o_gp_outputs,
      .o_counter_zero_gate, .o_irq_request, .o_gain_select, .o_analog_out0,
      .o_analog_out1);
   // Wide variant on the same bus and converter, checked on its read data.
   daq_host_register_interface #(.RESULT_BITS(16))
      daq_host_register_interface_w16_i (.i_clk, .i_resetn,
      .i_io_window_origin(ORG), .i_io_addr, .i_io_wr, .i_io_rd,
      .i_io_wdata, .o_io_rdata(rdata16), .o_io_rdata_oe(), .i_gp_inputs,
      .i_pacer_tick, .i_polarity_indication, .i_single_ended, .i_conv_done,
      .i_conv_result({4'h0, i_conv_result}), .o_conv_start(),
      .o_conv_input(), .o_gp_outputs(), .o_counter_zero_gate(),
      .o_irq_request(), .o_gain_select(), .o_analog_out0(),
      .o_analog_out1());
   conv_model conv_model_i (.i_clk, .i_start(o_conv_start),
      .i_value(conv_value), .o_done(i_conv_done), .o_result(i_conv_result));

   always #2 i_clk = ~i_clk;

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   always @(posedge i_clk)
   begin
      cyc <= cyc + 1;
      starts <= starts + ((o_conv_start === 1'b1) ? 1 : 0);
      if (cyc == 4000)
      begin
         error_cnt++;
         give_verdict();
      end
   end

   task automatic chk(input string n, input logic [11:0] e,
                      input logic [11:0] g);
      n_tests++;
      if (g !== e)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [11:0] o, input logic [7:0] d);
      @(negedge i_clk);
      i_io_addr = ORG + {4'h0, o};
      i_io_wdata = d;
      i_io_wr = 1'b1;
      @(negedge i_clk);
      i_io_wr = 1'b0;
   endtask

   task automatic rd(input logic [11:0] o, input logic [7:0] e,
                     input logic [7:0] m = 8'hFF);
      i_io_addr = ORG + {4'h0, o};
      i_io_rd = 1'b1;
      @(negedge i_clk);
      i_io_rd = 1'b0;
      rd16 = rdata16;
      chk("read enable", 12'h001, {11'h0, o_io_rdata_oe});
      chk($sformatf("offset %h", o), {4'h0, e}, {4'h0, o_io_rdata & m});
      @(negedge i_clk);
   endtask

   task automatic convert(input logic [11:0] v, input logic [3:0] ch);
      int k;
      conv_value = v;
      wr(OFS_RESULT_LO, 8'h00);
      chk("start", 12'h001, {11'h0, o_conv_start});
      chk("input", {8'h0, ch}, {8'h0, o_conv_input});
      rd(OFS_STATUS, 8'h80, 8'h80);
      for (k = 0; k < 40 && i_conv_done !== 1'b1; k++)
         @(negedge i_clk);
      @(negedge i_clk);
   endtask

   initial
   begin
      int         i;
      int         n0;
      logic [4:0] t;
      logic [3:0] ch;
      repeat (3) @(negedge i_clk);
      i_resetn = 1'b1;
      rd(OFS_EXTERNAL_START_INPUT_CTRL, RESET_BYTE);
      wr(OFS_SCAN_LIMITS, 8'h53);
      rd(OFS_SCAN_LIMITS, 8'h53);
      rd(OFS_STATUS, 8'h43);
      wr(OFS_EXTERNAL_START_INPUT_CTRL, 8'h80);
      rd(OFS_EXTERNAL_START_INPUT_CTRL, 8'h80);
      for (i = 0; i < 4; i++)
      begin
         ch = (i == 3) ? 4'h3 : 4'(3 + i);
         convert(12'hA50 + 12'(i), ch);
         chk("irq", 12'h001, {11'h0, o_irq_request});
         rd(OFS_RESULT_LO, {conv_value[3:0], ch});
         chk("wide low", {4'h0, conv_value[7:0]}, {4'h0, rd16});
         rd(OFS_RESULT_HI, conv_value[11:4]);
         chk("wide high", {8'h0, conv_value[11:8]}, {4'h0, rd16});
         wr(OFS_STATUS, 8'h5A);
         chk("irq clear", 12'h000, {11'h0, o_irq_request});
      end
      convert(12'h123, 4'h4);
      rd(OFS_RESULT_LO, 8'h34);
      convert(12'hFED, 4'h5);
      wr(OFS_RESULT_HI, 8'hFF);
      rd(OFS_RESULT_HI, 8'h12);
      rd(OFS_RESULT_LO, 8'hD5);
      rd(OFS_RESULT_HI, 8'hFE);
      convert(12'h111, 4'h3);
      convert(12'h222, 4'h4);
      wr(OFS_SCAN_LIMITS, 8'h53);
      rd(OFS_RESULT_LO, 8'hD5);
      for (i = 0; i < 2; i++)
      begin
         wr(12'(OFS_AOUT0_LO + 2 * i), 8'hC0);
         chk("aout held", 12'h000, i ? o_analog_out1 : o_analog_out0);
         wr(12'(OFS_AOUT0_HI + 2 * i), 8'hAB);
         chk("aout", 12'hABC, i ? o_analog_out1 : o_analog_out0);
      end
      foreach (WO[j]) rd(WO[j], UNDEF_READ);
      wr(OFS_BURST_ENABLE, 8'h01);
      wr(OFS_EXT_ENABLE, 8'h01);
      rd(OFS_EXT_STATUS, 8'h06);
      wr(OFS_PORT_A, 8'h3C);
      rd(OFS_PORT_A, 8'h3C);
      wr(OFS_GAIN, 8'hFE);
      chk("gain", 12'h002, {10'h0, o_gain_select});
      rd(OFS_GAIN, 8'h02);
      i_io_addr = ORG + 16'h0010;
      i_io_rd = 1'b1;
      @(negedge i_clk);
      i_io_rd = 1'b0;
      chk("unmapped enable", 12'h000, {11'h0, o_io_rdata_oe});
      wr(OFS_NIBBLE_DIO, 8'hF9);
      chk("digital out", 12'h009, {8'h0, o_gp_outputs});
      i_gp_inputs = 4'h4;
      repeat (8) @(negedge i_clk);
      rd(OFS_NIBBLE_DIO, 8'h04);
      chk("gate", 12'h001, {11'h0, o_counter_zero_gate});
      i_gp_inputs = 4'h0;
      wr(OFS_CONV_ENABLE, 8'h01);
      rd(OFS_EXT_STATUS, 8'h07);
      foreach (TCASE[j])
      begin
         t = TCASE[j];
         wr(OFS_EXTERNAL_START_INPUT_CTRL, {6'h00, t[4:3]});
         wr(OFS_BURST_PACING, {7'h00, t[2]});
         n0 = starts;
         i_gp_inputs = {3'b000, t[1]};
         repeat (8) @(negedge i_clk);
         i_pacer_tick = 1'b1;
         @(negedge i_clk);
         i_pacer_tick = 1'b0;
         repeat (8) @(negedge i_clk);
         i_gp_inputs = 4'h0;
         chk("hw starts", {11'h0, t[0]}, 12'(starts - n0));
      end
      give_verdict();
   end
endmodule
